// ===== rtl/mdpb_cfg.svh
// Constants of the motor driver parameter bank: command codes, resets, ranges.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef MDPB_CFG_SVH
`define MDPB_CFG_SVH

// =====================================================================
// Command codes (read codes, and configure sent as is; a write code adds the write offset).
`define MDPB_WR_OFS 16'h1000
`define MDPB_CC_JOG_SPEED 16'h0143
`define MDPB_CC_SIGN_MODE 16'h01E0
`define MDPB_CC_EDIT_ALLOW 16'h01E1
`define MDPB_CC_RUN_MODE 16'h0816
`define MDPB_CC_JOG_TORQUE 16'h0821
`define MDPB_CC_BRAKE_SEL 16'h0840
`define MDPB_CC_INIT_NOOP 16'h0841
`define MDPB_CC_THERMAL_EN 16'h0843
`define MDPB_CC_STARTUP_VIEW 16'h0870
`define MDPB_CC_ANALOG_SEL 16'h0871
`define MDPB_CC_COMM_TMO 16'h0900
`define MDPB_CC_ERR_LIMIT 16'h0901
`define MDPB_CC_CONFIGURE 16'h0F00

// =====================================================================
// Reset values.
`define MDPB_RST_JOG_SPEED 32'h0000012C
`define MDPB_RST_SIGN_MODE 32'h00000000
`define MDPB_RST_EDIT_ALLOW 32'h00000001
`define MDPB_RST_RUN_MODE 32'h00000000
`define MDPB_RST_JOG_TORQUE 32'h000000C8
`define MDPB_RST_BRAKE_SEL 32'h00000001
`define MDPB_RST_INIT_NOOP 32'h00000000
`define MDPB_RST_THERMAL_EN 32'h00000000
`define MDPB_RST_STARTUP_VIEW 32'h00000000
`define MDPB_RST_ANALOG_SEL 32'h00000001
`define MDPB_RST_COMM_TMO 32'h00000000
`define MDPB_RST_ERR_LIMIT 32'h00000003

// =====================================================================
// Allowed ranges.
`define MDPB_JOG_SPEED_MIN 32'h00000050
`define MDPB_JOG_SPEED_MAX 32'h000003E8
`define MDPB_JOG_TORQUE_MAX 32'h000000C8
`define MDPB_ONE_BIT_MAX 32'h00000001
`define MDPB_VIEW_MAX 32'h00000004
`define MDPB_ANALOG_MAX 32'h00000002
`define MDPB_TMO_MAX 32'h00002710
`define MDPB_ERR_MIN 32'h00000001
`define MDPB_ERR_MAX 32'h0000000A

// =====================================================================
// Timing: milliseconds to clock cycles at 20 MHz.
`define MDPB_CLK_HZ 32'd20000000
`define MDPB_MS_CYCLES (`MDPB_CLK_HZ / 32'd1000)

`endif

// ===== rtl/mdpb_pkg.sv
// Types shared by the parameter bank files.
// Assumes the cfg header supplies all numeric constants.
package mdpb_pkg;
  // =====================================================================
  // Analog source selection.
  typedef enum logic [1:0] {
    MDPB_ANALOG_OFF,
    MDPB_ANALOG_SPEED,
    MDPB_ANALOG_TORQUE
  } mdpb_src_e;

  // Command handling sequence.
  typedef enum logic [1:0] {
    MDPB_IDLE,
    MDPB_READ,
    MDPB_ANSWER
  } mdpb_state_e;

  typedef logic [31:0] mdpb_word_t;
endpackage

// ===== rtl/mdpb_mem.sv
// Register storage of the parameter bank, one word per parameter slot.
// Assumes one writer and one reader per cycle; read data comes from a register.
`include "mdpb_cfg.svh"
module mdpb_mem #(
  parameter int DEPTH = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire mdpb_pkg::mdpb_word_t wdata_i,
  input wire logic [3:0] raddr_i,
  output mdpb_pkg::mdpb_word_t rdata_o,
  output mdpb_pkg::mdpb_word_t word_o [DEPTH]
);
  initial begin
    if (DEPTH < 1 || DEPTH > 16) begin
      $error("mdpb_mem: DEPTH must be 1 to 16");
    end
  end

  // =====================================================================
  // Reset values, indexed by slot.
  function automatic mdpb_pkg::mdpb_word_t reset_val(input int idx);
    case (idx)
      0: reset_val = `MDPB_RST_JOG_SPEED;
      1: reset_val = `MDPB_RST_SIGN_MODE;
      2: reset_val = `MDPB_RST_EDIT_ALLOW;
      3: reset_val = `MDPB_RST_RUN_MODE;
      4: reset_val = `MDPB_RST_JOG_TORQUE;
      5: reset_val = `MDPB_RST_BRAKE_SEL;
      6: reset_val = `MDPB_RST_INIT_NOOP;
      7: reset_val = `MDPB_RST_THERMAL_EN;
      8: reset_val = `MDPB_RST_STARTUP_VIEW;
      9: reset_val = `MDPB_RST_ANALOG_SEL;
      10: reset_val = `MDPB_RST_COMM_TMO;
      11: reset_val = `MDPB_RST_ERR_LIMIT;
      default: reset_val = 32'h00000000;
    endcase
  endfunction

  // =====================================================================
  // Each slot is a word register; the flat view feeds the owner's decode.
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    mdpb_pkg::mdpb_word_t mem_q;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q <= reset_val(g);
      end else if (we_i && waddr_i == 4'(g)) begin
        mem_q <= wdata_i;
      end
    end
    assign word_o[g] = mem_q;
  end

  // Registered read port.
  mdpb_pkg::mdpb_word_t rdata_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= word_o[raddr_i];
    end
  end
  assign rdata_o = rdata_q;
endmodule

// ===== rtl/mdpb_timeout.sv
// Communication timeout watchdog: counts idle milliseconds between commands.
// Assumes a limit of zero means the link is not watched.
`include "mdpb_cfg.svh"
module mdpb_timeout #(
  parameter int MS_CYCLES = `MDPB_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic activity_i,
  input wire logic [13:0] limit_ms_i,
  output logic expired_o
);
  initial begin
    if (MS_CYCLES < 1) begin
      $error("mdpb_timeout: MS_CYCLES must be at least 1");
    end
  end

  // =====================================================================
  // Prescaler to 1 ms ticks, then millisecond counter.
  logic [31:0] pre_q;
  logic [13:0] ms_q;
  logic expired_q;
  wire tick = (pre_q == 32'(MS_CYCLES - 1));
  wire watching = (limit_ms_i != 14'h0000);

  // Any activity restarts the watch; an unwatched link never expires.
  always_ff @(posedge clk_i) begin
    if (rst_i || activity_i || !watching) begin
      pre_q <= 32'h00000000;
      ms_q <= 14'h0000;
      expired_q <= 1'b0;
    end else if (tick) begin
      pre_q <= 32'h00000000;
      if (ms_q != limit_ms_i) begin
        ms_q <= ms_q + 14'h0001;
      end
      expired_q <= (ms_q + 14'h0001 >= limit_ms_i);
    end else begin
      pre_q <= pre_q + 32'h00000001;
    end
  end
  assign expired_o = expired_q;
endmodule

// ===== rtl/mdpb_bank.sv
// Parameter bank of a brushless motor driver, reached by paired command codes.
// Assumes a command master that presents one command per strobe and waits
// for the answer pulse before the next command.
//
// Behaviour
// - Jog speed takes 0 or 80..1000, resets 300; jog torque 0..200, resets 200.
// - Speed display: 0 signed, 1 magnitude; resets 0; applies at once.
// - Panel editing: 0 blocked, 1 allowed; resets 1; applies at once.
// - Run mode 0 enables output shut-off mode, 1 disables it.
// - Alarm brake: 0 locks after coasting, 1 locks at once; resets 1.
// - Initial-alarm no-operation flag, 0 disabled, resets 0.
// - Initial thermal detection, 1 enabled, resets 0, applies after configuration.
// - Start-up view selects one of five items 0..4, resets 0.
// - Analog source: 0 ignored, 1 speed, 2 torque; resets 1.
// - At 1 only entry 0 speed is analog; rest digital.
// - At 0 everything digital; at 2 torque limit analog, speeds digital.
// - No other analog/digital sourcing combination is accepted.
// - Timeout 0 unmonitored, else 1..10000 ms; resets 0; applies at once.
// - Error alarm rises when error count reaches threshold 1..10, reset 3.
// - Immediate settings apply as soon as the write completes.
// - Deferred settings keep old value until configuration or power cycle.
// - Each request that cannot be carried out counts one communication error.
`include "mdpb_cfg.svh"
module mdpb_bank #(
  parameter int MS_CYCLES = `MDPB_MS_CYCLES,
  parameter int NUM_PARAMS = 12
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire logic [15:0] CMD_CODE_I,
  input wire logic [31:0] CMD_DATA_I,
  input wire logic ERR_CLEAR_I,
  output logic ACK_O,
  output logic NAK_O,
  output logic [31:0] RDATA_O,
  output logic [9:0] JOG_SPEED_O,
  output logic [7:0] JOG_TORQUE_O,
  output logic SPEED_ABS_O,
  output logic PANEL_EDIT_O,
  output logic SHUTOFF_EN_O,
  output logic BRAKE_IMMEDIATE_O,
  output logic INIT_NOOP_EN_O,
  output logic THERMAL_DETECT_EN_O,
  output logic [2:0] STARTUP_VIEW_O,
  output logic ENTRY0_SPEED_ANALOG_O,
  output logic TORQUE_LIMIT_ANALOG_O,
  output logic COMM_TIMEOUT_O,
  output logic COMM_ALARM_O,
  output logic [3:0] ERR_COUNT_O
);
  initial begin
    if (NUM_PARAMS != 12) begin
      $error("mdpb_bank: NUM_PARAMS must be 12");
    end
  end

  // =====================================================================
  // Command decode.
  // Maps a read code to its slot; returns 4'hF when the code is unknown.
  function automatic logic [3:0] slot_of(input logic [15:0] code);
    case (code)
      `MDPB_CC_JOG_SPEED: slot_of = 4'h0;
      `MDPB_CC_SIGN_MODE: slot_of = 4'h1;
      `MDPB_CC_EDIT_ALLOW: slot_of = 4'h2;
      `MDPB_CC_RUN_MODE: slot_of = 4'h3;
      `MDPB_CC_JOG_TORQUE: slot_of = 4'h4;
      `MDPB_CC_BRAKE_SEL: slot_of = 4'h5;
      `MDPB_CC_INIT_NOOP: slot_of = 4'h6;
      `MDPB_CC_THERMAL_EN: slot_of = 4'h7;
      `MDPB_CC_STARTUP_VIEW: slot_of = 4'h8;
      `MDPB_CC_ANALOG_SEL: slot_of = 4'h9;
      `MDPB_CC_COMM_TMO: slot_of = 4'hA;
      `MDPB_CC_ERR_LIMIT: slot_of = 4'hB;
      default: slot_of = 4'hF;
    endcase
  endfunction

  // Range check per slot; anything outside leaves the slot untouched.
  function automatic logic in_range(input logic [3:0] slot, input logic [31:0] v);
    case (slot)
      4'h0: in_range = (v == 32'h00000000) ||
                       (v >= `MDPB_JOG_SPEED_MIN && v <= `MDPB_JOG_SPEED_MAX);
      4'h4: in_range = (v <= `MDPB_JOG_TORQUE_MAX);
      4'h8: in_range = (v <= `MDPB_VIEW_MAX);
      4'h9: in_range = (v <= `MDPB_ANALOG_MAX);
      4'hA: in_range = (v <= `MDPB_TMO_MAX);
      4'hB: in_range = (v >= `MDPB_ERR_MIN && v <= `MDPB_ERR_MAX);
      4'hF: in_range = 1'b0;
      default: in_range = (v <= `MDPB_ONE_BIT_MAX);
    endcase
  endfunction

  // Write codes sit exactly the write offset above the read codes.
  wire [15:0] rd_equiv = CMD_CODE_I - `MDPB_WR_OFS;
  wire is_write_cmd = (CMD_CODE_I[15:12] == 4'h1);
  wire [3:0] rd_slot = slot_of(CMD_CODE_I);
  wire [3:0] wr_slot = slot_of(rd_equiv);
  wire is_config = (CMD_CODE_I == `MDPB_CC_CONFIGURE);
  wire rd_ok = !is_write_cmd && (rd_slot != 4'hF);
  wire wr_ok = is_write_cmd && in_range(wr_slot, CMD_DATA_I);
  wire cmd_ok = rd_ok || wr_ok || is_config;

  // =====================================================================
  // Sequencer: a read waits one cycle for the registered memory port.
  mdpb_pkg::mdpb_state_e state_q, state_d;
  logic ack_q, nak_q;
  logic [31:0] rdata_q;
  wire take = (state_q == mdpb_pkg::MDPB_IDLE) && CMD_VALID_I;
  wire mem_we = take && wr_ok;
  mdpb_pkg::mdpb_word_t mem_rdata;
  mdpb_pkg::mdpb_word_t word [NUM_PARAMS];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mdpb_pkg::MDPB_IDLE: begin
        if (take && rd_ok) begin
          state_d = mdpb_pkg::MDPB_READ;
        end else if (take) begin
          state_d = mdpb_pkg::MDPB_ANSWER;
        end
      end
      mdpb_pkg::MDPB_READ: state_d = mdpb_pkg::MDPB_ANSWER;
      mdpb_pkg::MDPB_ANSWER: state_d = mdpb_pkg::MDPB_IDLE;
    endcase
  end

  // Outcome of the command is latched at take and shown in ANSWER.
  logic ok_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= mdpb_pkg::MDPB_IDLE;
      ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        ok_q <= cmd_ok;
      end
    end
  end

  // Answer pulse with read data; a write or config echoes zero.
  wire answering = (state_d == mdpb_pkg::MDPB_ANSWER);
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      nak_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= answering && (state_q == mdpb_pkg::MDPB_READ ? ok_q : cmd_ok);
      nak_q <= answering && !(state_q == mdpb_pkg::MDPB_READ ? ok_q : cmd_ok);
      if (answering) begin
        rdata_q <= (state_q == mdpb_pkg::MDPB_READ) ? mem_rdata : 32'h00000000;
      end
    end
  end

  mdpb_mem #(
    .DEPTH(NUM_PARAMS)
  ) u_mem (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .we_i(mem_we),
    .waddr_i(wr_slot),
    .wdata_i(CMD_DATA_I),
    .raddr_i(rd_slot),
    .rdata_o(mem_rdata),
    .word_o(word)
  );

  // =====================================================================
  // Communication error counter and alarm.
  // A refused command is one error; saturation stops wrap-around from
  // silently clearing the error count.
  logic [3:0] err_q;
  logic alarm_q;
  wire err_event = take && !cmd_ok;
  wire [3:0] err_limit = word[11][3:0];
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      err_q <= 4'h0;
      alarm_q <= 1'b0;
    end else if (err_event) begin
      if (err_q != 4'hF) begin
        err_q <= err_q + 4'h1;
      end
      alarm_q <= alarm_q || (err_q + 4'h1 >= err_limit);
    end else if (ERR_CLEAR_I) begin
      err_q <= 4'h0;
      alarm_q <= 1'b0;
    end
  end

  // =====================================================================
  // Timeout watchdog; any command taken, refused or not, counts as activity.
  logic tmo_w;
  mdpb_timeout #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tmo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .activity_i(take),
    .limit_ms_i(word[10][13:0]),
    .expired_o(tmo_w)
  );
  logic tmo_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tmo_q <= 1'b0;
    end else begin
      tmo_q <= tmo_w;
    end
  end

  // =====================================================================
  // Deferred thermal setting: operating copy moves only on configure.
  logic thermal_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      thermal_q <= 1'(`MDPB_RST_THERMAL_EN);
    end else if (take && is_config) begin
      thermal_q <= word[7][0];
    end
  end

  // =====================================================================
  // Operating outputs, registered one cycle after the stored word changes.
  // Immediate settings thus appear two cycles after the write is taken, one after its answer.
  wire [1:0] src = word[9][1:0];
  logic [9:0] jog_speed_q;
  logic [7:0] jog_torque_q;
  logic [2:0] view_q;
  logic abs_q, edit_q, shut_q, brake_q, noop_q, ana_spd_q, ana_trq_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      jog_speed_q <= 10'(`MDPB_RST_JOG_SPEED);
      jog_torque_q <= 8'(`MDPB_RST_JOG_TORQUE);
      abs_q <= 1'b0;
      edit_q <= 1'b1;
      shut_q <= 1'b1;
      brake_q <= 1'b1;
      noop_q <= 1'b0;
      view_q <= 3'h0;
      ana_spd_q <= 1'b1;
      ana_trq_q <= 1'b0;
    end else begin
      jog_speed_q <= word[0][9:0];
      jog_torque_q <= word[4][7:0];
      abs_q <= word[1][0];
      edit_q <= word[2][0];
      shut_q <= !word[3][0];
      brake_q <= word[5][0];
      noop_q <= word[6][0];
      view_q <= word[8][2:0];
      ana_spd_q <= (src == 2'(mdpb_pkg::MDPB_ANALOG_SPEED));
      ana_trq_q <= (src == 2'(mdpb_pkg::MDPB_ANALOG_TORQUE));
    end
  end

  assign ACK_O = ack_q;
  assign NAK_O = nak_q;
  assign RDATA_O = rdata_q;
  assign JOG_SPEED_O = jog_speed_q;
  assign JOG_TORQUE_O = jog_torque_q;
  assign SPEED_ABS_O = abs_q;
  assign PANEL_EDIT_O = edit_q;
  assign SHUTOFF_EN_O = shut_q;
  assign BRAKE_IMMEDIATE_O = brake_q;
  assign INIT_NOOP_EN_O = noop_q;
  assign THERMAL_DETECT_EN_O = thermal_q;
  assign STARTUP_VIEW_O = view_q;
  assign ENTRY0_SPEED_ANALOG_O = ana_spd_q;
  assign TORQUE_LIMIT_ANALOG_O = ana_trq_q;
  assign COMM_TIMEOUT_O = tmo_q;
  assign COMM_ALARM_O = alarm_q;
  assign ERR_COUNT_O = err_q;
endmodule

// ===== bench/mdpb_bank_properties.sv
// Concurrent checks on the parameter bank ports.
// Assumes it is bound onto mdpb_bank with one clock and a synchronous reset.
`include "mdpb_cfg.svh"
module mdpb_bank_properties #(
  parameter int MS_CYCLES = 4,
  parameter int NUM_PARAMS = 12
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire logic [15:0] CMD_CODE_I,
  input wire logic ERR_CLEAR_I,
  input wire logic ACK_O,
  input wire logic NAK_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [9:0] JOG_SPEED_O,
  input wire logic THERMAL_DETECT_EN_O,
  input wire logic ENTRY0_SPEED_ANALOG_O,
  input wire logic TORQUE_LIMIT_ANALOG_O,
  input wire logic COMM_ALARM_O,
  input wire logic [3:0] ERR_COUNT_O
);
  logic busy_q;
  logic [15:0] code_q;

  // ==========================================================================
  // Command tracking.
  // The tracker mirrors the one-command-at-a-time contract, so strobes seen while busy are not takes.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      busy_q <= 1'b0;
      code_q <= 16'h0000;
    end else if (CMD_VALID_I && !busy_q) begin
      busy_q <= 1'b1;
      code_q <= CMD_CODE_I;
    end else if (ACK_O || NAK_O) begin
      busy_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Properties.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence seq_take;
    CMD_VALID_I && !busy_q;
  endsequence
  sequence seq_answer;
    ACK_O || NAK_O;
  endsequence
  chk_answer_timing: assert property (seq_take |-> ##[1:2] seq_answer)
    else $error("answer not one or two cycles after command");
  chk_write_answer: assert property (seq_take ##0 CMD_CODE_I[12] |-> ##1 seq_answer)
    else $error("write answer not one cycle after command");
  chk_answer_pulse: assert property (seq_answer |=> !(ACK_O || NAK_O) && !ACK_O)
    else $error("answer longer than one cycle");
  chk_nak_counts: assert property (NAK_O && !ERR_CLEAR_I && !$past(ERR_CLEAR_I) |-> ERR_COUNT_O != 4'h0)
    else $error("refusal without error count");
  chk_rdata_hold: assert property (!(ACK_O || NAK_O) |-> $stable(RDATA_O))
    else $error("read data moved between answers");
  chk_jog_range: assert property (JOG_SPEED_O == 10'h000 || (JOG_SPEED_O >= 10'h050 && JOG_SPEED_O <= 10'h3E8))
    else $error("jog speed outside allowed range");
  chk_jog_change: assert property ($changed(JOG_SPEED_O) |-> $past(ACK_O))
    else $error("jog speed changed outside an answer");
  chk_thermal_config: assert property ($changed(THERMAL_DETECT_EN_O) |-> code_q == `MDPB_CC_CONFIGURE)
    else $error("thermal detect changed without configure");
  chk_analog_excl: assert property (!(ENTRY0_SPEED_ANALOG_O && TORQUE_LIMIT_ANALOG_O))
    else $error("speed and torque both analog");
  chk_alarm_sticky: assert property (COMM_ALARM_O && !ERR_CLEAR_I |=> COMM_ALARM_O)
    else $error("alarm dropped without clear");
endmodule

// ===== bench/mdpb_master_model.sv
// Behavioural command master for the parameter bank.
// Assumes the bench calls one task at a time, only after reset is released.
`include "mdpb_cfg.svh"
module mdpb_master_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic nak_i,
  input wire logic [31:0] rdata_i,
  output logic valid_o,
  output logic [15:0] code_o,
  output logic [31:0] data_o
);
  // ==========================================================================
  // Idle drive.
  initial begin
    valid_o = 1'b0;
    code_o = 16'h0000;
    data_o = 32'h00000000;
  end

  // One command; the strobe stands for the taking edge only, since a held strobe
  // could be taken again once the bank is idle. Released lines show the inverse.
  task automatic send(input logic [15:0] code, input logic [31:0] data, output logic [1:0] resp,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    valid_o <= 1'b1;
    code_o <= code;
    data_o <= data;
    @(posedge clk_i);
    valid_o <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && nak_i !== 1'b1 && n < 20);
    resp = {nak_i, ack_i};
    rd = rdata_i;
    code_o <= ~code;
    data_o <= ~data;
  endtask

  // Writes reach a parameter through its read code moved by the write offset.
  task automatic wr(input logic [15:0] rcode, input logic [31:0] v, output logic [1:0] resp);
    logic [31:0] rd_dummy;
    send(rcode + `MDPB_WR_OFS, v, resp, rd_dummy);
  endtask

  task automatic rd(input logic [15:0] rcode, output logic [1:0] resp, output logic [31:0] v);
    send(rcode, ~data_o, resp, v);
  endtask
endmodule

// ===== bench/mdpb_bank_tb.sv
// Self-checking bench for the motor driver parameter bank.
// Assumes the master model drives the command port and the checker is bound below.
`include "mdpb_cfg.svh"
module mdpb_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, err_clear, cmd_valid, ack, nak;
  logic [15:0] cmd_code;
  logic [31:0] cmd_data, rdata;
  logic [9:0] jog_speed;
  logic [7:0] jog_torque;
  logic speed_abs, edit, shutoff, brake, noop, thermal, e0_an, tq_an, tmo, alarm;
  logic [2:0] view;
  logic [3:0] err_count;
  int failures = 0;
  int comparisons = 0;
  int exp_err = 0;
  logic [15:0] codes [12] = '{`MDPB_CC_JOG_SPEED, `MDPB_CC_SIGN_MODE, `MDPB_CC_EDIT_ALLOW, `MDPB_CC_RUN_MODE,
    `MDPB_CC_JOG_TORQUE, `MDPB_CC_BRAKE_SEL, `MDPB_CC_INIT_NOOP, `MDPB_CC_THERMAL_EN, `MDPB_CC_STARTUP_VIEW,
    `MDPB_CC_ANALOG_SEL, `MDPB_CC_COMM_TMO, `MDPB_CC_ERR_LIMIT};
  logic [31:0] rsts [12] = '{32'h12C, 32'h0, 32'h1, 32'h0, 32'hC8, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h3};
  logic [31:0] maxs [12] = '{32'h3E8, 32'h1, 32'h1, 32'h1, 32'hC8, 32'h1, 32'h1, 32'h1, 32'h4, 32'h2, 32'h2710,
    32'hA};

  // ==========================================================================
  // Clock, reset and instances.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  mdpb_bank #(.MS_CYCLES(4), .NUM_PARAMS(12)) DUT (.CLK_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid),
    .CMD_CODE_I(cmd_code), .CMD_DATA_I(cmd_data), .ERR_CLEAR_I(err_clear), .ACK_O(ack), .NAK_O(nak),
    .RDATA_O(rdata), .JOG_SPEED_O(jog_speed), .JOG_TORQUE_O(jog_torque), .SPEED_ABS_O(speed_abs),
    .PANEL_EDIT_O(edit), .SHUTOFF_EN_O(shutoff), .BRAKE_IMMEDIATE_O(brake), .INIT_NOOP_EN_O(noop),
    .THERMAL_DETECT_EN_O(thermal), .STARTUP_VIEW_O(view), .ENTRY0_SPEED_ANALOG_O(e0_an),
    .TORQUE_LIMIT_ANALOG_O(tq_an), .COMM_TIMEOUT_O(tmo), .COMM_ALARM_O(alarm), .ERR_COUNT_O(err_count));
  mdpb_master_model u_master (.clk_i(clk), .ack_i(ack), .nak_i(nak), .rdata_i(rdata), .valid_o(cmd_valid),
    .code_o(cmd_code), .data_o(cmd_data));

  // ==========================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [15:0] rcode, input logic [31:0] v);
    logic [1:0] resp;
    u_master.wr(rcode, v, resp);
    @(negedge clk);
    check("write answer", 32'(resp), 32'h1);
  endtask
  task automatic get(input logic [15:0] rcode, input logic [31:0] exp);
    logic [1:0] resp;
    logic [31:0] v;
    u_master.rd(rcode, resp, v);
    check("read answer", 32'(resp), 32'h1);
    check("read value", v, exp);
  endtask
  // A refused command must count one error, saturating at fifteen.
  task automatic bad(input logic [15:0] code, input logic [31:0] v);
    logic [1:0] resp;
    logic [31:0] rd;
    u_master.send(code, v, resp, rd);
    check("refusal", 32'(resp), 32'h2);
    exp_err = (exp_err == 15) ? 15 : exp_err + 1;
    check("error count", 32'(err_count), 32'(exp_err));
  endtask
  task automatic clear_errors();
    @(posedge clk);
    err_clear <= 1'b1;
    @(posedge clk);
    err_clear <= 1'b0;
    repeat (2) @(posedge clk);
    exp_err = 0;
    check("cleared errors", 32'({alarm, err_count}), 32'h0);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset_values();
    check("reset outputs", 32'({jog_speed, jog_torque, speed_abs, edit, shutoff, brake, noop, thermal, view, e0_an,
      tq_an, tmo, alarm}), 32'({10'h12C, 8'hC8, 6'b011100, 3'h0, 4'b1000}));
    for (int i = 0; i < 12; i++) get(codes[i], rsts[i]);
  endtask
  task automatic t_range_limits();
    for (int i = 0; i < 12; i++) begin
      put(codes[i], maxs[i]);
      bad(codes[i] + `MDPB_WR_OFS, maxs[i] + 32'h1);
      get(codes[i], maxs[i]);
    end
    bad(`MDPB_CC_JOG_SPEED + `MDPB_WR_OFS, 32'h4F);
    put(`MDPB_CC_JOG_SPEED, 32'h50);
    check("jog speed", 32'(jog_speed), 32'h50);
    put(`MDPB_CC_JOG_SPEED, 32'h0);
    check("jog speed", 32'(jog_speed), 32'h0);
    put(`MDPB_CC_JOG_TORQUE, 32'h64);
    check("jog torque", 32'(jog_torque), 32'h64);
    bad(`MDPB_CC_ERR_LIMIT + `MDPB_WR_OFS, 32'h0);
    bad(16'h0777, 32'h0);
    bad(16'h1777, 32'h5);
  endtask
  task automatic t_live_outputs();
    for (int v = 0; v < 2; v++) begin
      put(`MDPB_CC_SIGN_MODE, 32'(v));
      check("speed display", 32'(speed_abs), 32'(v));
      put(`MDPB_CC_EDIT_ALLOW, 32'(v));
      check("panel edit", 32'(edit), 32'(v));
      put(`MDPB_CC_RUN_MODE, 32'(v));
      check("shut off", 32'(shutoff), 32'(v == 0));
      put(`MDPB_CC_BRAKE_SEL, 32'(v));
      check("brake", 32'(brake), 32'(v));
      put(`MDPB_CC_INIT_NOOP, 32'(v));
      check("initial noop", 32'(noop), 32'(v));
    end
    for (int v = 0; v < 5; v++) begin
      put(`MDPB_CC_STARTUP_VIEW, 32'(v));
      check("startup view", 32'(view), 32'(v));
    end
    for (int v = 0; v < 3; v++) begin
      put(`MDPB_CC_ANALOG_SEL, 32'(v));
      check("analog source", 32'({e0_an, tq_an}), 32'({v == 1, v == 2}));
    end
    bad(`MDPB_CC_ANALOG_SEL + `MDPB_WR_OFS, 32'h3);
    check("analog source", 32'({e0_an, tq_an}), 32'h1);
  endtask
  task automatic t_deferred();
    for (int v = 1; v >= 0; v--) begin
      put(`MDPB_CC_THERMAL_EN, 32'(v));
      check("thermal before", 32'(thermal), 32'(v == 0));
      get(`MDPB_CC_THERMAL_EN, 32'(v));
      put(`MDPB_CC_CONFIGURE - `MDPB_WR_OFS, 32'h0);
      @(posedge clk);
      check("thermal after", 32'(thermal), 32'(v));
    end
  endtask
  task automatic t_alarm();
    clear_errors();
    put(`MDPB_CC_ERR_LIMIT, 32'h2);
    for (int k = 0; k < 2; k++) begin
      bad(16'h0777, 32'h0);
      @(posedge clk);
      check("alarm", 32'(alarm), 32'(k));
    end
    clear_errors();
    put(`MDPB_CC_ERR_LIMIT, 32'h1);
    bad(16'h1999, 32'h0);
    @(posedge clk);
    check("alarm", 32'(alarm), 32'h1);
    clear_errors();
  endtask
  task automatic t_timeout();
    int n;
    put(`MDPB_CC_COMM_TMO, 32'h2);
    n = 0;
    while (tmo !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check("timeout delay", 32'(n >= 4 && n <= 10), 32'h1);
    get(`MDPB_CC_COMM_TMO, 32'h2);
    check("timeout cleared", 32'(tmo), 32'h0);
    put(`MDPB_CC_COMM_TMO, 32'h0);
    repeat (40) @(posedge clk);
    check("unmonitored", 32'(tmo), 32'h0);
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence.
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    err_clear = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_range_limits();
    t_live_outputs();
    t_deferred();
    t_alarm();
    t_timeout();
    stop_test();
  end
endmodule

bind mdpb_bank mdpb_bank_properties #(.MS_CYCLES(MS_CYCLES), .NUM_PARAMS(NUM_PARAMS)) u_chk (.CLK_I(CLK_I),
  .RST_I(RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I), .ERR_CLEAR_I(ERR_CLEAR_I), .ACK_O(ACK_O),
  .NAK_O(NAK_O), .RDATA_O(RDATA_O), .JOG_SPEED_O(JOG_SPEED_O), .THERMAL_DETECT_EN_O(THERMAL_DETECT_EN_O),
  .ENTRY0_SPEED_ANALOG_O(ENTRY0_SPEED_ANALOG_O), .TORQUE_LIMIT_ANALOG_O(TORQUE_LIMIT_ANALOG_O),
  .COMM_ALARM_O(COMM_ALARM_O), .ERR_COUNT_O(ERR_COUNT_O));
